/* dv/testbench.sv */
// Self-checking testbench of the serial port control block
`timescale 1ns/10ps
module testbench;
  logic clk_i, srst_i, wr_i, rd_i, dab, stall;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, tx_data_o, rx_data;
  logic [3:0] ev;
  logic rx_valid, rx_ready, tx_valid_o, tx_ready, irq_o, undr_o, dma_o, fen_o;
  int err_total, samples_checked;
  uif_ctrl dut_u (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .divisor_access_bit_i(dab),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_data_i(rx_data), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready), .tx_data_o(tx_data_o), .line_err_i(ev[0]), .modem_change_i(ev[1]),
    .tx_underrun_i(ev[2]), .char_tick_i(ev[3]), .irq_pending_o(irq_o),
    .tx_underrun_irq_o(undr_o), .dma_mode_o(dma_o), .fifo_enable_o(fen_o));
  uif_line_model line_u (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .rx_data_o(rx_data), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready),
    .tx_data_i(tx_data_o), .stall_i(stall));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic setd(input logic v);
    @(posedge clk_i);
    dab <= v;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask
  task automatic t_reset;
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h01);
    chk({7'h0, irq_o}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_mask;
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h2F);
    setd(1'b1);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'h00);
    setd(1'b0);
    rd(3'h1, 8'h2F);
    wr(3'h1, 8'h02);
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h01);
    @(posedge clk_i);
    stall <= 1'b1;
    wr(3'h0, 8'h5A);
    idle(4);
    chk({7'h0, tx_valid_o}, 8'h01);
    chk(tx_data_o, 8'h5A);
    rd(3'h2, 8'h02);
    @(posedge clk_i);
    stall <= 1'b0;
    idle(3);
    chk(line_u.tx_last, 8'h5A);
    wr(3'h1, 8'h00);
    $display("test mask done");
  endtask
  task automatic t_fifo;
    wr(3'h2, 8'h21);
    rd(3'h2, 8'hC1);
    chk({7'h0, fen_o}, 8'h01);
    setd(1'b1);
    wr(3'h2, 8'h21);
    setd(1'b0);
    rd(3'h2, 8'hE1);
    wr(3'h2, 8'h09);
    rd(3'h2, 8'hE1);
    chk({7'h0, dma_o}, 8'h01);
    wr(3'h2, 8'h08);
    rd(3'h2, 8'h01);
    chk({7'h0, dma_o}, 8'h00);
    setd(1'b1);
    wr(3'h2, 8'h01);
    setd(1'b0);
    $display("test fifo done");
  endtask
  task automatic t_trig;
    logic [6:0] lv [4];
    lv = '{7'h01, 7'h04, 7'h08, 7'h0E};
    wr(3'h1, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(3'h2, {c[1:0], 6'h03});
      for (int i = 0; i < lv[c]; i++) begin
        if (i == lv[c] - 1) begin
          idle(3);
          rd(3'h2, 8'hC1);
        end
        line_u.send(8'(i));
      end
      idle(3);
      rd(3'h2, 8'hC4);
    end
    rd(3'h0, 8'h00);
    rd(3'h2, 8'hC1);
    for (int k = 0; k < 4; k++) pulse(4'h8);
    rd(3'h2, 8'hCC);
    rd(3'h0, 8'h01);
    rd(3'h2, 8'hC1);
    wr(3'h2, 8'hC3);
    line_u.send(8'h77);
    idle(3);
    rd(3'h0, 8'h77);
    $display("test trigger done");
  endtask
  task automatic t_trig64;
    setd(1'b1);
    wr(3'h2, 8'h63);
    setd(1'b0);
    for (int i = 0; i < 15; i++) line_u.send(8'(i));
    idle(3);
    rd(3'h2, 8'hE1);
    line_u.send(8'h0F);
    idle(3);
    rd(3'h2, 8'hE4);
    setd(1'b1);
    wr(3'h2, 8'h03);
    setd(1'b0);
    rd(3'h2, 8'hC1);
    $display("test 64-byte trigger done");
  endtask
  task automatic t_txrst;
    int n;
    @(posedge clk_i);
    stall <= 1'b1;
    wr(3'h0, 8'hA1);
    wr(3'h0, 8'hA2);
    wr(3'h0, 8'hA3);
    n = line_u.tx_count;
    wr(3'h2, 8'hC5);
    @(posedge clk_i);
    stall <= 1'b0;
    idle(6);
    chk(8'(line_u.tx_count - n), 8'h01);
    chk(line_u.tx_last, 8'hA1);
    $display("test transmit flush done");
  endtask
  task automatic t_events;
    wr(3'h1, 8'h2C);
    pulse(4'h1);
    pulse(4'h2);
    chk({7'h0, irq_o}, 8'h01);
    rd(3'h2, 8'hC6);
    rd(3'h5, 8'h00);
    rd(3'h2, 8'hC0);
    rd(3'h6, 8'h00);
    rd(3'h2, 8'hC1);
    pulse(4'h4);
    idle(2);
    chk({7'h0, undr_o}, 8'h01);
    rd(3'h2, 8'hC1);
    idle(2);
    chk({7'h0, undr_o}, 8'h00);
    $display("test events done");
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    dab = 1'b0;
    stall = 1'b0;
    ev = 4'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset;
    t_mask;
    t_fifo;
    t_trig;
    t_trig64;
    t_txrst;
    t_events;
    stop_test;
  end
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
endmodule

/* dv/uif_ctrl_monitor.sv */
// Checker of the serial port control block, bound to its top module
`timescale 1ns/10ps
module uif_ctrl_monitor (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Register port
  input wire [2:0] addr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire divisor_access_bit_i,
  // Transmit side
  input wire tx_valid_o,
  input wire tx_ready_i,
  input wire [7:0] tx_data_o,
  // Status
  input wire irq_pending_o,
  input wire dma_mode_o,
  input wire fifo_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_id_rd;
    rd_i && addr_i == 3'h2;
  endsequence
  sequence s_lo_rd;
    rd_i && addr_i < 3'h2 && divisor_access_bit_i;
  endsequence
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  AST_DMA: assert property (dma_mode_o |-> fifo_enable_o)
    else $error("dma mode without fifo");
  AST_FST: assert property (s_id_rd |=> {rdata_o[7:6], rdata_o[4]} == {{2{fifo_enable_o}}, 1'b0})
    else $error("fifo state field wrong");
  AST_PEND: assert property (s_id_rd |=> rdata_o[0] != irq_pending_o)
    else $error("pending bit disagrees with pending output");
  AST_DAB: assert property (s_lo_rd |=> rdata_o == 8'h00)
    else $error("low offset answered under divisor access");
  AST_HI: assert property (rd_i && addr_i > 3'h2 |=> rdata_o == 8'h00)
    else $error("unmapped offset not zero");
  AST_TXHOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("transmit byte dropped while stalled");
  AST_MASK_RD: assert property (rd_i && addr_i == 3'h1 |=> rdata_o[7:6] == 2'h0 && !rdata_o[4])
    else $error("unused mask bits read set");
endmodule
bind uif_ctrl uif_ctrl_monitor mon_u (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .divisor_access_bit_i(divisor_access_bit_i),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
  .irq_pending_o(irq_pending_o), .dma_mode_o(dma_mode_o), .fifo_enable_o(fifo_enable_o));

/* dv/uif_line_model.sv */
// Far side model: hands received bytes in and takes transmitted bytes
`timescale 1ns/10ps
module uif_line_model (
  // Clock
  input wire clk_i,
  // Receive stream
  output logic rx_valid_o,
  input wire rx_ready_i,
  output logic [7:0] rx_data_o,
  // Transmit stream
  input wire tx_valid_i,
  output logic tx_ready_o,
  input wire [7:0] tx_data_i,
  input wire stall_i
);
  logic [7:0] tx_last = 8'h00;
  int tx_count = 0;
  assign tx_ready_o = !stall_i;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
  end
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      tx_last <= tx_data_i;
      tx_count <= tx_count + 1;
    end
  end
  // Holds the byte until taken or 100 further cycles pass; afterwards the data lines show the inverse
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
    @(posedge clk_i);
    while (!rx_ready_i && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b;
  endtask
endmodule

/* pkg/uif_map.vh */
// Register map, field positions and constants of the serial port control block
`ifndef UIF_MAP_VH
`define UIF_MAP_VH
`define UIF_OFF_DATA 3'h0
`define UIF_OFF_MASK 3'h1
`define UIF_OFF_IDENT 3'h2
`define UIF_OFF_LSTAT 3'h5
`define UIF_OFF_MSTAT 3'h6
`define UIF_MASK_RDA 0
`define UIF_MASK_THRE 1
`define UIF_MASK_RLS 2
`define UIF_MASK_MS 3
`define UIF_MASK_UNDR 5
`define UIF_MASK_USED 8'h2F
`define UIF_MASK_RST 8'h00
`define UIF_FC_EN 0
`define UIF_FC_RXRST 1
`define UIF_FC_TXRST 2
`define UIF_FC_DMA 3
`define UIF_FC_SIZE 5
`define UIF_FC_TRIG_HI 7
`define UIF_FC_TRIG_LO 6
`define UIF_ID_NONE 4'h1
`define UIF_ID_RLS 4'h6
`define UIF_ID_RDA 4'h4
`define UIF_ID_CTO 4'hC
`define UIF_ID_THRE 4'h2
`define UIF_ID_MS 4'h0
`define UIF_FST_OFF 3'h0
`define UIF_FST_16 3'h6
`define UIF_FST_64 3'h7
`define UIF_CAP_1 7'h01
`define UIF_CAP_16 7'h10
`define UIF_CAP_64 7'h40
`define UIF_TRIG16_0 7'h01
`define UIF_TRIG16_1 7'h04
`define UIF_TRIG16_2 7'h08
`define UIF_TRIG16_3 7'h0E
`define UIF_TRIG64_0 7'h01
`define UIF_TRIG64_1 7'h10
`define UIF_TRIG64_2 7'h20
`define UIF_TRIG64_3 7'h38
`define UIF_TMO_CHARS 3'h4
`define UIF_SKID_DEPTH 8
`define UIF_SKID_AW 3
`endif

/* src/uif_ctrl.v */
// Serial port host control: holding path, interrupt mask, identification, FIFO control
// Function
// (RL1) Data write with divisor access clear loads holding register or pushes transmit FIFO.
// (RL2) Mask bit 0 requests received-data interrupt when receive level reaches threshold.
// (RL3) Mask resets to zero; bits 1,2,3,5 gate their sources; 4,6,7 unused.
// (RL4) Line status interrupt, top priority, set by line errors, cleared by status read.
// (RL5) Received-data interrupt, second priority, from data or trigger; cleared by buffer read.
// (RL6) Time-out when FIFO non-empty and idle four character times; buffer read clears it.
// (RL7) Holding-empty interrupt, third priority; cleared by identification read or data write.
// (RL8) Modem-status interrupt, lowest, from modem changes, cleared by modem status read.
// (RL9) Identification bits 7:5 show FIFO state 000/110/111; bit 4 reads zero.
// (RL10) Control bit 0 enables both FIFOs; any change flushes both; others need it.
// (RL11) Control bit 1 empties the receive FIFO only, then clears itself.
// (RL12) Control bit 2 empties the transmit FIFO only, then clears itself.
// (RL13) Control bit 3 selects DMA mode when set, disables DMA when clear.
// (RL14) Control bit 5 picks 64 or 16 bytes; writable only with divisor access set.
// (RL15) Control bits 7:6 pick trigger 1/4/8/14 or 1/16/32/56 bytes.
// (RL16) Software clears divisor access before buffer, holding or mask accesses.
// (RL17) Divisor access set redirects data and mask offsets and allows size writes.
// (RL18) Identification bit 0 is 1 when idle, else 0 with highest source shown.
// (RL19) Offset 2 reads identification and writes FIFO control; mask needs divisor access clear.
`timescale 1ns/10ps
`include "uif_map.vh"

module uif_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] cnt;
  assign in_ready_o = (cnt != DEPTH[AW:0]);
  assign out_valid_o = (cnt != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop & ~push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule

module uif_ctrl (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Register port
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Line control state
  input wire divisor_access_bit_i,
  // Receive shifter side
  input wire rx_valid_i,
  output wire rx_ready_o,
  input wire [7:0] rx_data_i,
  // Transmit shifter side
  output reg tx_valid_o,
  input wire tx_ready_i,
  output reg [7:0] tx_data_o,
  // Events from line, modem and baud logic
  input wire line_err_i,
  input wire modem_change_i,
  input wire tx_underrun_i,
  input wire char_tick_i,
  // Status to the rest of the port
  output reg irq_pending_o,
  output reg tx_underrun_irq_o,
  output reg dma_mode_o,
  output reg fifo_enable_o
);
  reg [7:0] interrupt_mask;
  reg fifo_en;
  reg fifo_dma;
  reg fifo_size_select;
  reg [1:0] fifo_trig;
  reg [7:0] rx_mem [0:63];
  reg [5:0] rx_wp;
  reg [5:0] rx_rp;
  reg [6:0] rx_cnt;
  reg [7:0] tx_mem [0:63];
  reg [5:0] tx_wp;
  reg [5:0] tx_rp;
  reg [6:0] tx_cnt;
  reg lsi_flag;
  reg ms_flag;
  reg thre_flag;
  reg cto_flag;
  reg undr_flag;
  reg [2:0] tmo_cnt;
  wire [6:0] cap;
  reg [6:0] trig_level;
  reg [3:0] ident;
  wire [2:0] fifo_state;
  wire dab;
  wire wr_data;
  wire rd_data;
  wire wr_mask;
  wire wr_fctl;
  wire rd_ident;
  wire rd_lstat;
  wire rd_mstat;
  wire fc_change;
  wire rx_flush;
  wire tx_flush;
  wire sk_valid;
  wire sk_ready;
  wire [7:0] sk_data;
  wire rx_push;
  wire rx_pop;
  wire tx_push;
  wire tx_pop;
  wire [6:0] next_tx_cnt;
  wire rda_active;
  wire thre_set;

  assign dab = divisor_access_bit_i;
  assign wr_data = wr_i & (addr_i == `UIF_OFF_DATA) & ~dab; // RL16 RL17
  assign rd_data = rd_i & (addr_i == `UIF_OFF_DATA) & ~dab; // RL16 RL17
  assign wr_mask = wr_i & (addr_i == `UIF_OFF_MASK) & ~dab; // RL19
  assign wr_fctl = wr_i & (addr_i == `UIF_OFF_IDENT); // RL19
  assign rd_ident = rd_i & (addr_i == `UIF_OFF_IDENT); // RL19
  assign rd_lstat = rd_i & (addr_i == `UIF_OFF_LSTAT);
  assign rd_mstat = rd_i & (addr_i == `UIF_OFF_MSTAT);

  // Enable or size change flushes both; reset bits act only alongside an enable write
  assign fc_change = wr_fctl & ((wdata_i[`UIF_FC_EN] != fifo_en) // RL10
    | (dab & wdata_i[`UIF_FC_EN] & (wdata_i[`UIF_FC_SIZE] != fifo_size_select)));
  assign rx_flush = fc_change | (wr_fctl & wdata_i[`UIF_FC_EN] & wdata_i[`UIF_FC_RXRST]); // RL11
  assign tx_flush = fc_change | (wr_fctl & wdata_i[`UIF_FC_EN] & wdata_i[`UIF_FC_TXRST]); // RL12

  // Capacity and trigger level follow mode and size
  assign cap = !fifo_en ? `UIF_CAP_1 : (fifo_size_select ? `UIF_CAP_64 : `UIF_CAP_16);

  always @* begin
    trig_level = `UIF_TRIG16_0;
    if (fifo_en & fifo_size_select) begin
      case (fifo_trig) // RL15
        2'h0: trig_level = `UIF_TRIG64_0;
        2'h1: trig_level = `UIF_TRIG64_1;
        2'h2: trig_level = `UIF_TRIG64_2;
        default: trig_level = `UIF_TRIG64_3;
      endcase
    end else if (fifo_en) begin
      case (fifo_trig) // RL15
        2'h0: trig_level = `UIF_TRIG16_0;
        2'h1: trig_level = `UIF_TRIG16_1;
        2'h2: trig_level = `UIF_TRIG16_2;
        default: trig_level = `UIF_TRIG16_3;
      endcase
    end
  end

  // Receive input buffer between the shifter and the receive FIFO
  uif_fifo #(
    .WIDTH(8),
    .DEPTH(`UIF_SKID_DEPTH),
    .AW(`UIF_SKID_AW)
  ) u_skid (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i(rx_data_i),
    .out_valid_o(sk_valid),
    .out_ready_i(sk_ready),
    .out_data_o(sk_data)
  );

  assign sk_ready = (rx_cnt < cap) & ~rx_flush;
  assign rx_push = sk_valid & sk_ready;
  assign rx_pop = rd_data & (rx_cnt != 7'h00) & ~rx_flush;

  always @(posedge clk_i) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= sk_data;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      rx_wp <= 6'h00;
      rx_rp <= 6'h00;
      rx_cnt <= 7'h00;
    end else if (rx_flush) begin
      rx_wp <= 6'h00; // RL11
      rx_rp <= 6'h00;
      rx_cnt <= 7'h00;
    end else begin
      if (rx_push) begin
        rx_wp <= (rx_wp + 6'h01) & (cap[5:0] - 6'h01);
      end
      if (rx_pop) begin
        rx_rp <= (rx_rp + 6'h01) & (cap[5:0] - 6'h01);
      end
      if (rx_push & ~rx_pop) begin
        rx_cnt <= rx_cnt + 7'h01;
      end else if (rx_pop & ~rx_push) begin
        rx_cnt <= rx_cnt - 7'h01;
      end
    end
  end

  // Transmit path: holding register is the one-entry case of the FIFO
  assign tx_push = wr_data & (tx_cnt < cap) & ~tx_flush; // RL1
  assign tx_pop = (tx_cnt != 7'h00) & (~tx_valid_o | tx_ready_i) & ~tx_flush;
  assign next_tx_cnt = tx_flush ? 7'h00 :
                       (tx_push & ~tx_pop) ? tx_cnt + 7'h01 :
                       (tx_pop & ~tx_push) ? tx_cnt - 7'h01 : tx_cnt;

  always @(posedge clk_i) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= wdata_i; // RL1
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      tx_wp <= 6'h00;
      tx_rp <= 6'h00;
      tx_cnt <= 7'h00;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else begin
      tx_cnt <= next_tx_cnt;
      if (tx_flush) begin
        tx_wp <= 6'h00; // RL12
        tx_rp <= 6'h00;
      end else begin
        if (tx_push) begin
          tx_wp <= (tx_wp + 6'h01) & (cap[5:0] - 6'h01);
        end
        if (tx_pop) begin
          tx_rp <= (tx_rp + 6'h01) & (cap[5:0] - 6'h01);
        end
      end
      // Output stage belongs to the shifter and survives a flush
      if (tx_pop) begin
        tx_valid_o <= 1'b1;
        tx_data_o <= tx_mem[tx_rp];
      end else if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
    end
  end

  // Mask and FIFO control registers
  always @(posedge clk_i) begin
    if (srst_i) begin
      interrupt_mask <= `UIF_MASK_RST; // RL3
      fifo_en <= 1'b0;
      fifo_dma <= 1'b0;
      fifo_size_select <= 1'b0;
      fifo_trig <= 2'h0;
    end else begin
      if (wr_mask) begin
        interrupt_mask <= wdata_i & `UIF_MASK_USED; // RL3
      end
      if (wr_fctl) begin
        fifo_en <= wdata_i[`UIF_FC_EN]; // RL10
        if (wdata_i[`UIF_FC_EN]) begin
          fifo_dma <= wdata_i[`UIF_FC_DMA]; // RL13
          fifo_trig <= wdata_i[`UIF_FC_TRIG_HI:`UIF_FC_TRIG_LO]; // RL15
          if (dab) begin
            fifo_size_select <= wdata_i[`UIF_FC_SIZE]; // RL14
          end
        end
      end
    end
  end

  // Interrupt sources; a set in the cycle of its clear wins
  assign rda_active = (rx_cnt >= trig_level); // RL2 RL5
  assign thre_set = (next_tx_cnt == 7'h00) & (tx_cnt != 7'h00);

  always @(posedge clk_i) begin
    if (srst_i) begin
      lsi_flag <= 1'b0;
      ms_flag <= 1'b0;
      thre_flag <= 1'b1;
      cto_flag <= 1'b0;
      undr_flag <= 1'b0;
      tmo_cnt <= 3'h0;
    end else begin
      if (line_err_i) begin
        lsi_flag <= 1'b1; // RL4
      end else if (rd_lstat) begin
        lsi_flag <= 1'b0; // RL4
      end
      if (modem_change_i) begin
        ms_flag <= 1'b1; // RL8
      end else if (rd_mstat) begin
        ms_flag <= 1'b0; // RL8
      end
      if (thre_set) begin
        thre_flag <= 1'b1; // RL7
      end else if (wr_data | (rd_ident & (ident == `UIF_ID_THRE))) begin
        thre_flag <= 1'b0; // RL7
      end
      if (tx_underrun_i) begin
        undr_flag <= 1'b1;
      end else if (rd_ident) begin
        undr_flag <= 1'b0;
      end
      // Idle timer counts character times while data waits untouched
      if (!fifo_en || rx_cnt == 7'h00 || rx_push || rx_pop || rx_flush) begin
        tmo_cnt <= 3'h0; // RL6
      end else if (char_tick_i && tmo_cnt != `UIF_TMO_CHARS) begin
        tmo_cnt <= tmo_cnt + 3'h1; // RL6
      end
      if (fifo_en && rx_cnt != 7'h00 && char_tick_i && !rx_push && !rx_pop && !rx_flush
          && tmo_cnt == `UIF_TMO_CHARS - 3'h1) begin
        cto_flag <= 1'b1; // RL6
      end else if (rd_data || rx_flush || rx_cnt == 7'h00) begin
        cto_flag <= 1'b0; // RL6
      end
    end
  end

  // Priority encoder for identification
  always @* begin
    if (interrupt_mask[`UIF_MASK_RLS] & lsi_flag) begin
      ident = `UIF_ID_RLS; // RL4 RL18
    end else if (interrupt_mask[`UIF_MASK_RDA] & rda_active) begin
      ident = `UIF_ID_RDA; // RL5 RL18
    end else if (interrupt_mask[`UIF_MASK_RDA] & cto_flag) begin
      ident = `UIF_ID_CTO; // RL6
    end else if (interrupt_mask[`UIF_MASK_THRE] & thre_flag) begin
      ident = `UIF_ID_THRE; // RL7
    end else if (interrupt_mask[`UIF_MASK_MS] & ms_flag) begin
      ident = `UIF_ID_MS; // RL8
    end else begin
      ident = `UIF_ID_NONE; // RL18
    end
  end

  assign fifo_state = !fifo_en ? `UIF_FST_OFF : // RL9
                      (fifo_size_select ? `UIF_FST_64 : `UIF_FST_16);

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
      irq_pending_o <= 1'b0;
      tx_underrun_irq_o <= 1'b0;
      dma_mode_o <= 1'b0;
      fifo_enable_o <= 1'b0;
    end else begin
      rdata_o <= 8'h00;
      if (rd_data) begin
        rdata_o <= (rx_cnt != 7'h00) ? rx_mem[rx_rp] : 8'h00;
      end else if (rd_i && addr_i == `UIF_OFF_MASK && !dab) begin
        rdata_o <= interrupt_mask; // RL19
      end else if (rd_ident) begin
        rdata_o <= {fifo_state, 1'b0, ident}; // RL9 RL19
      end
      irq_pending_o <= (ident != `UIF_ID_NONE); // RL18
      tx_underrun_irq_o <= interrupt_mask[`UIF_MASK_UNDR] & undr_flag; // RL3
      dma_mode_o <= fifo_en & fifo_dma; // RL13
      fifo_enable_o <= fifo_en; // RL10
    end
  end
endmodule
